/* verilog/adc_result_computation_unit.sv */
// adc post-conversion computation: modes, accumulator, counter, tests
// assumes the conversion core pulses result_valid with current_result
//
// Contract
// - mode field selects five computation modes
// - basic mode flags done, never accumulates
// - samples from current or previous result
// - one cycle is one or two conversions
// - accumulate adds sample, counter saturates FF
// - accumulate flags done and tests every sample
// - average tests once counter reaches target
// - average clears at trigger when target reached
// - burst clears on start, keeps sum over retriggers
// - burst retriggers until counter reaches target
// - lpf adds sample minus shifted accumulator
// - lpf tests at target then every trigger
// - filter output is shifted accumulator
// - clear control zeroes accumulator, overflow, counter
// - overflow flag set beyond 65535
`timescale 1ns/1ps
module adc_result_computation_unit #(
   parameter int RES_W = adc_comp_pkg::RESULT_W
) (
   input wire logic clk_sys, // system clock, 125 MHz
   input wire logic resetn, // async reset, active low
   input wire logic [3:0] reg_addr, // register index
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   input wire logic trigger_in, // external trigger pulse from core
   input wire logic result_valid, // conversion finished pulse
   input wire logic [RES_W-1:0] current_result, // conversion result
   input wire logic threshold_true, // selected test condition holds
   output logic conversion_go, // request a conversion, one pulse
   output logic threshold_test, // test runs this cycle, one pulse
   output logic [15:0] filter_output, // scaled accumulator
   output logic conversion_done_flag, // sticky conversion done
   output logic threshold_hit_flag, // sticky threshold hit
   output logic accumulator_overflow // sticky overflow
);
   // ************************************************************
   // registers
   // ************************************************************
   logic [2:0] computation_mode_select;
   logic [2:0] shift_select;
   logic double_sample_enable;
   logic accumulator_clear;
   logic [7:0] repeat_target;
   logic [15:0] sample_accumulator;
   logic [RES_W-1:0] previous_result;
   logic [RES_W-1:0] last_result;
   logic second_half;
   logic busy;
   logic [7:0] sample_counter;
   logic sw_go;
   logic wr_ctrl;
   logic wr_stat;

   typedef enum logic [1:0] {IDLE, WAIT_CONV, RETRIG} seq_e;
   seq_e state;

   assign wr_ctrl = reg_wr && (reg_addr == adc_comp_pkg::REG_CTRL);
   assign wr_stat = reg_wr && (reg_addr == adc_comp_pkg::REG_STATUS);
   assign sw_go = wr_ctrl && reg_wdata[adc_comp_pkg::CTRL_GO_BIT];

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         computation_mode_select <= adc_comp_pkg::MODE_BASIC;
         shift_select <= '0;
         double_sample_enable <= 1'b0;
         repeat_target <= adc_comp_pkg::REPEAT_RESET;
      end else begin
         if (wr_ctrl) begin
            computation_mode_select <=
               reg_wdata[adc_comp_pkg::CTRL_MODE_LSB +: 3];
            shift_select <= reg_wdata[adc_comp_pkg::CTRL_SHIFT_LSB +: 3];
            double_sample_enable <=
               reg_wdata[adc_comp_pkg::CTRL_DSEN_BIT];
         end
         if (reg_wr && (reg_addr == adc_comp_pkg::REG_REPEAT)) begin
            repeat_target <= reg_wdata[7:0];
         end
      end
   end

   // ************************************************************
   // cycle bookkeeping
   // ************************************************************
   logic mode_acc;
   logic mode_avg;
   logic mode_burst;
   logic mode_lpf;
   logic at_target;
   logic cycle_end;
   logic start_evt;
   logic [RES_W-1:0] s1;
   logic [RES_W-1:0] s2;
   logic [15:0] next_acc;
   logic acc_ovf;
   logic pre_clear;
   logic do_update;
   logic [7:0] cnt_after;

   assign mode_acc = computation_mode_select == adc_comp_pkg::MODE_ACCUM;
   assign mode_avg = computation_mode_select == adc_comp_pkg::MODE_AVERAGE;
   assign mode_burst = computation_mode_select == adc_comp_pkg::MODE_BURST;
   assign mode_lpf = computation_mode_select == adc_comp_pkg::MODE_LPF;
   assign at_target = sample_counter >= repeat_target;
   assign start_evt = sw_go || trigger_in;

   // cycle closes on second conversion when pairing
   assign cycle_end = result_valid && (!double_sample_enable || second_half);

   assign s1 = double_sample_enable ? previous_result : current_result;
   assign s2 = current_result;

   // average clears at a trigger once target reached
   assign pre_clear = mode_avg && at_target && start_evt && !busy;
   assign do_update = cycle_end && (mode_acc || mode_avg || mode_burst
                                    || mode_lpf);

   acc_datapath #(
      .ACC_W(16),
      .RES_W(RES_W),
      .SH_W(3)
   ) u_acc (
      .acc(sample_accumulator),
      .s1(s1),
      .s2(s2),
      .dsen(double_sample_enable),
      .lpf(mode_lpf),
      .shift(shift_select),
      .next_acc(next_acc),
      .ovf(acc_ovf)
   );

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         second_half <= 1'b0;
         previous_result <= '0;
         last_result <= '0;
      end else if (result_valid) begin
         previous_result <= current_result;
         last_result <= current_result;
         second_half <= double_sample_enable && !second_half;
      end else if (start_evt && !busy) begin
         second_half <= 1'b0;
      end
   end

   // ************************************************************
   // sequencer, burst retrigger
   // ************************************************************
   logic start_seen;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= IDLE;
         conversion_go <= 1'b0;
         start_seen <= 1'b0;
      end else begin
         conversion_go <= 1'b0;
         start_seen <= start_evt && !busy; // mode written with go has landed
         case (state)
            IDLE: begin
               if (sw_go) begin
                  conversion_go <= 1'b1;
                  state <= WAIT_CONV;
               end else if (trigger_in) begin
                  state <= WAIT_CONV;
               end
            end
            WAIT_CONV: begin
               if (cycle_end && mode_burst && (cnt_after < repeat_target)) begin
                  state <= RETRIG;
               end else if (cycle_end) begin
                  state <= IDLE;
               end
            end
            RETRIG: begin
               conversion_go <= 1'b1;
               state <= WAIT_CONV;
            end
            default: state <= IDLE;
         endcase
      end
   end
   assign busy = state != IDLE;

   // counter value after this cycle's increment
   assign cnt_after = sample_counter
                    + {7'b0, sample_counter != adc_comp_pkg::CNT_MAX};

   // ************************************************************
   // accumulator and counter
   // ************************************************************
   logic burst_clear;
   // burst clears once per start, sum kept over repeats
   assign burst_clear = mode_burst && start_seen;

   // counter saturates at FF, clear control
   sample_counter_sat #(
      .WIDTH(8)
   ) u_cnt (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clear(accumulator_clear || burst_clear || pre_clear),
      .incr(do_update),
      .count(sample_counter)
   );

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sample_accumulator <= '0;
      end else if (accumulator_clear || burst_clear || pre_clear) begin
         sample_accumulator <= '0;
      end else if (do_update) begin
         sample_accumulator <= next_acc;
      end
   end

   // hardware drops the clear bit after one cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         accumulator_clear <= 1'b0;
      end else begin
         accumulator_clear <= wr_ctrl && reg_wdata[adc_comp_pkg::CTRL_CLR_BIT];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         filter_output <= '0;
      end else begin
         filter_output <= sample_accumulator >> shift_select;
      end
   end

   // ************************************************************
   // threshold test and flags
   // ************************************************************
   logic next_test;
   always_comb begin
      next_test = 1'b0;
      if (cycle_end) begin
         case (computation_mode_select)
            // test every sample in basic and accumulate
            adc_comp_pkg::MODE_BASIC: next_test = 1'b1;
            adc_comp_pkg::MODE_ACCUM: next_test = 1'b1;
            adc_comp_pkg::MODE_AVERAGE: next_test =
               cnt_after >= repeat_target;
            adc_comp_pkg::MODE_BURST: next_test =
               cnt_after >= repeat_target;
            // lpf tests at target and every later trigger
            adc_comp_pkg::MODE_LPF: next_test =
               cnt_after >= repeat_target;
            default: next_test = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         threshold_test <= 1'b0;
      end else begin
         threshold_test <= next_test;
      end
   end

   // done and threshold flags clear by writing one to status, overflow by the clear control; a set in the same cycle wins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         conversion_done_flag <= 1'b0;
         threshold_hit_flag <= 1'b0;
         accumulator_overflow <= 1'b0;
      end else begin
         if (result_valid) begin
            conversion_done_flag <= 1'b1;
         end else if (wr_stat && reg_wdata[adc_comp_pkg::STAT_DONE_BIT]) begin
            conversion_done_flag <= 1'b0;
         end
         if (threshold_test && threshold_true) begin
            threshold_hit_flag <= 1'b1;
         end else if (wr_stat && reg_wdata[adc_comp_pkg::STAT_THR_BIT]) begin
            threshold_hit_flag <= 1'b0;
         end
         if (do_update && acc_ovf) begin
            accumulator_overflow <= 1'b1;
         end else if (accumulator_clear) begin
            accumulator_overflow <= 1'b0;
         end
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            adc_comp_pkg::REG_CTRL: reg_rdata <= {21'h0, 1'b0,
               accumulator_clear, double_sample_enable, 1'b0,
               shift_select, 1'b0, computation_mode_select};
            adc_comp_pkg::REG_REPEAT: reg_rdata <= {24'h0, repeat_target};
            adc_comp_pkg::REG_STATUS: reg_rdata <= {28'h0, busy,
               accumulator_overflow, threshold_hit_flag,
               conversion_done_flag};
            adc_comp_pkg::REG_ACC: reg_rdata <= {16'h0, sample_accumulator};
            adc_comp_pkg::REG_FILTER: reg_rdata <= {16'h0, filter_output};
            adc_comp_pkg::REG_COUNT: reg_rdata <= {24'h0, sample_counter};
            adc_comp_pkg::REG_PREV: reg_rdata <=
               {{(32-RES_W){1'b0}}, previous_result};
            adc_comp_pkg::REG_RESULT: reg_rdata <=
               {{(32-RES_W){1'b0}}, last_result};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule : adc_result_computation_unit

/* verilog/adc_comp_pkg.sv */
// constants for the adc result computation unit
// assumes one clock domain shared with the conversion core
package adc_comp_pkg;
   localparam int RESULT_W = 10;
   localparam int ACC_W = 16;
   localparam int CNT_W = 8;
   localparam int SHIFT_W = 3;
   localparam int MODE_W = 3;
   // register index map, byte address is four times the index
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_REPEAT = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_ACC = 4'h3;
   localparam logic [3:0] REG_FILTER = 4'h4;
   localparam logic [3:0] REG_COUNT = 4'h5;
   localparam logic [3:0] REG_PREV = 4'h6;
   localparam logic [3:0] REG_RESULT = 4'h7;
   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SHIFT_LSB = 4;
   localparam int CTRL_DSEN_BIT = 8;
   localparam int CTRL_CLR_BIT = 9;
   localparam int CTRL_GO_BIT = 10;
   // status register fields
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_THR_BIT = 1;
   localparam int STAT_OVF_BIT = 2;
   localparam int STAT_BUSY_BIT = 3;
   // mode codes
   localparam logic [2:0] MODE_BASIC = 3'h0;
   localparam logic [2:0] MODE_ACCUM = 3'h1;
   localparam logic [2:0] MODE_AVERAGE = 3'h2;
   localparam logic [2:0] MODE_BURST = 3'h3;
   localparam logic [2:0] MODE_LPF = 3'h4;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] REPEAT_RESET = 8'h00;
endpackage : adc_comp_pkg

/* verilog/sample_counter_sat.sv */
// saturating sample counter with synchronous clear
// assumes clear and increment come from the same clock domain
`timescale 1ns/1ps
module sample_counter_sat #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic clear, // zero the count
   input wire logic incr, // add one unless saturated
   output logic [WIDTH-1:0] count // current count
);
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (incr && (count != {WIDTH{1'b1}})) begin
         count <= count + 1'b1;
      end
   end
endmodule : sample_counter_sat

/* verilog/acc_datapath.sv */
// accumulator next-value arithmetic with overflow detection
// purely combinational, fed by the registered accumulator
`timescale 1ns/1ps
module acc_datapath #(
   parameter int ACC_W = 16,
   parameter int RES_W = 10,
   parameter int SH_W = 3
) (
   input wire logic [ACC_W-1:0] acc, // present accumulator
   input wire logic [RES_W-1:0] s1, // sample one
   input wire logic [RES_W-1:0] s2, // sample two
   input wire logic dsen, // use s2 - s1
   input wire logic lpf, // subtract scaled accumulator
   input wire logic [SH_W-1:0] shift, // shift select
   output logic [ACC_W-1:0] next_acc, // accumulator after update
   output logic ovf // result left the 16-bit range
);
   logic [ACC_W+1:0] term;
   logic [ACC_W+1:0] decay;
   logic [ACC_W+1:0] sum;
   always_comb begin
      if (dsen) begin
         term = {{(ACC_W+2-RES_W){1'b0}}, s2}
              - {{(ACC_W+2-RES_W){1'b0}}, s1};
      end else begin
         term = {{(ACC_W+2-RES_W){1'b0}}, s1};
      end
      decay = lpf ? {2'b00, acc >> shift} : '0;
      sum = term + {2'b00, acc} - decay;
      next_acc = sum[ACC_W-1:0];
      ovf = (sum[ACC_W+1:ACC_W] != 2'b00);
   end
endmodule : acc_datapath

/* dv/adc_comp_assertions.sv */
// port-level checks for the adc result computation unit
// bound to the top module, single clock domain
`timescale 1ns/1ps
module adc_comp_assertions (
   input wire logic clk_sys, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic [3:0] reg_addr, // register index
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic trigger_in, // trigger pulse
   input wire logic result_valid, // conversion finished
   input wire logic threshold_true, // test condition
   input wire logic conversion_go, // conversion request
   input wire logic threshold_test, // test pulse
   input wire logic [15:0] filter_output, // scaled accumulator
   input wire logic conversion_done_flag, // done flag
   input wire logic threshold_hit_flag, // threshold flag
   input wire logic accumulator_overflow // overflow flag
);
   // ****************************************
   // helpers and assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic ctl_wr, st_wr;
   assign ctl_wr = reg_wr && reg_addr == adc_comp_pkg::REG_CTRL;
   assign st_wr = reg_wr && reg_addr == adc_comp_pkg::REG_STATUS;
   sequence s_cleared;
      ##[1:4] (!accumulator_overflow && filter_output == 16'h0000);
   endsequence
   AST_DONE_SET: assert property (result_valid |-> ##[1:2] conversion_done_flag)
      else $error("done flag not set after conversion");
   AST_DONE_HOLD: assert property (conversion_done_flag && !st_wr
      && !$past(st_wr) |=> conversion_done_flag)
      else $error("done flag dropped");
   AST_THR_SET: assert property (threshold_test && threshold_true
      |-> ##[1:2] threshold_hit_flag)
      else $error("threshold flag not set");
   AST_THR_ROSE: assert property ($rose(threshold_hit_flag)
      |-> $past(threshold_test && threshold_true))
      else $error("threshold flag set without a true test");
   AST_TEST_CAUSE: assert property (threshold_test |-> $past(result_valid))
      else $error("threshold test without a cycle end");
   AST_GO_CAUSE: assert property (conversion_go |-> $past(ctl_wr && reg_wdata[10])
      || $past(result_valid, 2) || $past(result_valid, 3))
      else $error("conversion request without a cause");
   AST_OVF_HOLD: assert property (accumulator_overflow && !ctl_wr
      && !$past(ctl_wr) |=> accumulator_overflow)
      else $error("overflow flag dropped");
   AST_CLEAR: assert property (ctl_wr && reg_wdata[9] |-> s_cleared)
      else $error("clear did not zero overflow and filter");
   AST_FILT_CAUSE: assert property ($changed(filter_output)
      |-> $past(result_valid) || $past(result_valid, 2) || $past(reg_wr)
      || $past(reg_wr, 2) || $past(reg_wr, 3) || $past(trigger_in, 2)
      || $past(trigger_in, 3))
      else $error("filter output changed without a cause");
endmodule : adc_comp_assertions

/* dv/conv_core_model.sv */
// conversion core stand-in: answers each request with a result
// assumes the clock of the computation unit
`timescale 1ns/1ps
module conv_core_model #(
   parameter int LAT = 3
) (
   input wire logic clk_sys, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic req, // start from the bench
   input wire logic conversion_go, // start from the unit
   input wire logic [9:0] value, // result to return
   output logic result_valid, // result pulse
   output logic [9:0] current_result // result, inverted except in the result_valid cycle
);
   int cnt;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt <= 0;
         result_valid <= 1'b0;
         current_result <= 10'h000;
      end else begin
         result_valid <= cnt == 1;
         current_result <= (cnt == 1) ? value : ~value;
         if (req || conversion_go) begin
            cnt <= LAT;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule : conv_core_model

/* dv/adc_result_computation_unit_bench.sv */
// self-checking bench for the adc result computation unit
// assumes the conversion core model and the checker beside it
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module adc_result_computation_unit_bench;
   // ****************************************
   // stimulus and checks
   // ****************************************
   logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic trigger_in = 1'b0, threshold_true = 1'b0, req = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [9:0] value = 10'h000, current_result;
   logic [15:0] filter_output;
   logic result_valid, conversion_go, threshold_test;
   logic conversion_done_flag, threshold_hit_flag, accumulator_overflow;
   int num_errors = 0, compares = 0, ntest = 0, ngo = 0, t0, g0, i;
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (threshold_test === 1'b1) ntest <= ntest + 1;
      if (conversion_go === 1'b1) ngo <= ngo + 1;
   end
   adc_result_computation_unit dut_u (.clk_sys(clk_sys), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_in(trigger_in),
      .result_valid(result_valid), .current_result(current_result),
      .threshold_true(threshold_true), .conversion_go(conversion_go),
      .threshold_test(threshold_test), .filter_output(filter_output),
      .conversion_done_flag(conversion_done_flag),
      .threshold_hit_flag(threshold_hit_flag),
      .accumulator_overflow(accumulator_overflow));
   conv_core_model model_u (.clk_sys(clk_sys), .resetn(resetn), .req(req),
      .conversion_go(conversion_go), .value(value),
      .result_valid(result_valid), .current_result(current_result));
   function automatic logic [31:0] ctl(int m, int s, int d, int c, int g);
      return 32'(m | (s << 4) | (d << 8) | (c << 9) | (g << 10));
   endfunction : ctl
   task automatic conclude();
      if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
      @(posedge clk_sys);
   endtask : rd
   task automatic conv(input logic [9:0] v);
      int k;
      value <= v;
      req <= 1'b1;
      trigger_in <= 1'b1;
      @(posedge clk_sys);
      req <= 1'b0;
      trigger_in <= 1'b0;
      for (k = 0; k < 20 && result_valid !== 1'b1; k++) @(posedge clk_sys);
      if (k == 20) begin
         num_errors++;
         conclude();
      end
      repeat (3) @(posedge clk_sys);
   endtask : conv
   initial begin
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      wr(adc_comp_pkg::REG_CTRL, ctl(0, 0, 0, 1, 0));
      t0 = ntest;
      conv(10'h064);
      `CHK("conversion_done_flag", 1'b1, conversion_done_flag)
      `CHK("threshold_hit_flag", 1'b0, threshold_hit_flag)
      rd(adc_comp_pkg::REG_ACC, 32'h0);
      rd(4'h9, 32'h0);
      threshold_true <= 1'b1;
      wr(adc_comp_pkg::REG_CTRL, ctl(1, 1, 0, 1, 0));
      t0 = ntest;
      conv(10'h064);
      conv(10'h0C8);
      rd(adc_comp_pkg::REG_ACC, 32'h12C);
      `CHK("filter_output", 16'h0096, filter_output)
      `CHK("threshold_test", 2, ntest - t0)
      `CHK("threshold_hit_flag", 1'b1, threshold_hit_flag)
      wr(adc_comp_pkg::REG_CTRL, ctl(1, 0, 1, 1, 0));
      t0 = ntest;
      conv(10'h032);
      conv(10'h050);
      rd(adc_comp_pkg::REG_ACC, 32'h1E);
      rd(adc_comp_pkg::REG_COUNT, 32'h1);
      `CHK("threshold_test", 1, ntest - t0)
      wr(adc_comp_pkg::REG_REPEAT, 32'h2);
      wr(adc_comp_pkg::REG_CTRL, ctl(2, 0, 0, 1, 0));
      t0 = ntest;
      conv(10'h00A);
      `CHK("threshold_test", 0, ntest - t0)
      conv(10'h014);
      `CHK("threshold_test", 1, ntest - t0)
      conv(10'h005);
      rd(adc_comp_pkg::REG_ACC, 32'h5);
      rd(adc_comp_pkg::REG_COUNT, 32'h1);
      wr(adc_comp_pkg::REG_CTRL, ctl(4, 1, 0, 1, 0));
      t0 = ntest;
      conv(10'h064);
      `CHK("threshold_test", 0, ntest - t0)
      conv(10'h064);
      conv(10'h064);
      rd(adc_comp_pkg::REG_ACC, 32'hAF);
      `CHK("threshold_test", 2, ntest - t0)
      wr(adc_comp_pkg::REG_REPEAT, 32'h3);
      value <= 10'h007;
      t0 = ntest;
      g0 = ngo;
      wr(adc_comp_pkg::REG_CTRL, ctl(3, 0, 0, 0, 1));
      for (i = 0; i < 200 && ntest == t0; i++) @(posedge clk_sys);
      if (i == 200) begin
         num_errors++;
         conclude();
      end
      repeat (4) @(posedge clk_sys);
      `CHK("conversion_go", 3, ngo - g0)
      rd(adc_comp_pkg::REG_COUNT, 32'h3);
      rd(adc_comp_pkg::REG_ACC, 32'h15);
      wr(adc_comp_pkg::REG_CTRL, ctl(1, 0, 0, 1, 0));
      for (i = 0; i < 260; i++) conv(10'h3E8);
      `CHK("accumulator_overflow", 1'b1, accumulator_overflow)
      rd(adc_comp_pkg::REG_COUNT, 32'hFF);
      wr(adc_comp_pkg::REG_CTRL, ctl(1, 0, 0, 1, 0));
      rd(adc_comp_pkg::REG_CTRL, 32'h1);
      rd(adc_comp_pkg::REG_COUNT, 32'h0);
      `CHK("accumulator_overflow", 1'b0, accumulator_overflow)
      wr(adc_comp_pkg::REG_STATUS, 32'h3);
      rd(adc_comp_pkg::REG_STATUS, 32'h0);
      conclude();
   end
endmodule : adc_result_computation_unit_bench
bind adc_result_computation_unit adc_comp_assertions chk_u (
   .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .trigger_in(trigger_in),
   .result_valid(result_valid),
   .threshold_true(threshold_true), .conversion_go(conversion_go),
   .threshold_test(threshold_test), .filter_output(filter_output),
   .conversion_done_flag(conversion_done_flag),
   .threshold_hit_flag(threshold_hit_flag),
   .accumulator_overflow(accumulator_overflow));
